// *** verilog/ppc_cfg.svh ***
`ifndef PPC_CFG_SVH
`define PPC_CFG_SVH
// Register byte offsets on the AHB-Lite bus
`define PPC_OFS_B_ANSEL   12'h000
`define PPC_OFS_B_WPU     12'h004
`define PPC_OFS_OPTION    12'h008
`define PPC_OFS_B_DATA    12'h00C
`define PPC_OFS_B_DIR     12'h010
`define PPC_OFS_B_LAT     12'h014
`define PPC_OFS_C_DATA    12'h018
`define PPC_OFS_C_DIR     12'h01C
`define PPC_OFS_C_LAT     12'h020
`define PPC_OFS_C_ANSEL   12'h024
// Implemented bit masks and reset values
`define PPC_B_ANSEL_MASK  8'h30
`define PPC_B_ANSEL_RST   8'h30
`define PPC_B_WPU_MASK    8'hF0
`define PPC_B_WPU_RST     8'hF0
`define PPC_DIR_RST       8'hFF
`define PPC_LAT_RST       8'h00
`define PPC_C_ANSEL_RST   8'hFF
`define PPC_PU_DIS_RST    1'h1
`define PPC_PU_DIS_BIT    0
`define PPC_ADDR_LSB      2
`define PPC_ADDR_W        12
`define PPC_IDX_W         4
`endif

// *** verilog/ppc_pkg.sv ***
package ppc_pkg;
  typedef enum logic [1:0] {
    PPC_IDLE = 2'b00,
    PPC_WR   = 2'b01,
    PPC_RD   = 2'b10
  } ppc_phase_t;
endpackage

// *** verilog/ppc_sync.sv ***
`timescale 1ns/1ps
// Two-flop synchroniser for a bus of pin levels
module ppc_sync #(
  parameter int W = 8
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta_r;

  // First stage feeds only the second
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_r <= '0;
      q      <= '0;
    end else begin
      meta_r <= d;
      q      <= meta_r;
    end
  end
endmodule // ppc_sync

// *** verilog/ppc_top.sv ***
// The register offsets and register access over AHB-Lite are this design's own decisions.
`timescale 1ns/1ps
`include "ppc_cfg.svh"
module ppc_top
  import ppc_pkg::*;
#(
  parameter int C_W = 8
) (
  input  wire logic          CLK,
  input  wire logic          RST_N,
  input  wire logic          HSEL,
  input  wire logic [31:0]   HADDR,
  input  wire logic [1:0]    HTRANS,
  input  wire logic          HWRITE,
  input  wire logic [2:0]    HSIZE,
  input  wire logic [31:0]   HWDATA,
  input  wire logic          HREADY,
  output logic      [31:0]   HRDATA,
  output logic               HREADYOUT,
  output logic               HRESP,
  input  wire logic [7:0]    B_PIN_LEVEL,
  output logic      [7:0]    B_PIN_DRIVE,
  output logic      [7:0]    B_PIN_OE,
  output logic      [7:0]    B_PULLUP,
  output logic      [7:0]    B_ANALOG,
  input  wire logic [C_W-1:0] C_PIN_LEVEL,
  output logic      [C_W-1:0] C_PIN_DRIVE,
  output logic      [C_W-1:0] C_PIN_OE,
  output logic      [C_W-1:0] C_ANALOG
);
  logic [7:0]     b_ansel_r;
  logic [7:0]     b_wpu_r;
  logic           pu_dis_n_r;
  logic [7:0]     b_dir_r;
  logic [7:0]     b_lat_r;
  logic [C_W-1:0] c_dir_r;
  logic [C_W-1:0] c_lat_r;
  logic [C_W-1:0] c_ansel_r;
  logic [7:0]     b_pin_s;
  logic [C_W-1:0] c_pin_s;
  logic [7:0]     b_rd;
  logic [C_W-1:0] c_rd;
  ppc_phase_t     ph_r;
  logic [`PPC_ADDR_W-1:0] adr_r;
  logic [31:0]    rdata_nxt;
  logic           take;

  // Pins come from outside the clock domain
  ppc_sync #(.W(8)) u_sync_b (
    .clk   (CLK),
    .rst_n (RST_N),
    .d     (B_PIN_LEVEL),
    .q     (b_pin_s)
  );
  ppc_sync #(.W(C_W)) u_sync_c (
    .clk   (CLK),
    .rst_n (RST_N),
    .d     (C_PIN_LEVEL),
    .q     (c_pin_s)
  );

  // Digital read path; analog pins have buffer off
  assign b_rd = b_pin_s & ~b_ansel_r;
  assign c_rd = c_pin_s & ~c_ansel_r;

  // Data write helper: pin image is masked off, written byte taken as is
  function automatic logic [7:0] rmw(input logic [7:0] pins,
                                     input logic [31:0] wd);
    rmw = (pins & 8'h00) | wd[7:0];
  endfunction

  // Address phase accepted on a valid transfer
  assign take = HSEL && HREADY && HTRANS[1];

  // Zero wait state slave, always OKAY
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      ph_r  <= PPC_IDLE;
      adr_r <= '0;
    end else if (HREADY) begin
      ph_r  <= !take ? PPC_IDLE : (HWRITE ? PPC_WR : PPC_RD);
      adr_r <= HADDR[`PPC_ADDR_W-1:0];
    end
  end

  // Configuration registers; unimplemented bits masked
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      b_ansel_r  <= `PPC_B_ANSEL_RST;
      b_wpu_r    <= `PPC_B_WPU_RST;
      pu_dis_n_r <= `PPC_PU_DIS_RST;
      b_dir_r    <= `PPC_DIR_RST;
      c_dir_r    <= C_W'(`PPC_DIR_RST);
      c_ansel_r  <= C_W'(`PPC_C_ANSEL_RST);
    end else if (ph_r == PPC_WR) begin
      unique case (adr_r)
        `PPC_OFS_B_ANSEL: b_ansel_r <= HWDATA[7:0] & `PPC_B_ANSEL_MASK;
        `PPC_OFS_B_WPU:   b_wpu_r   <= HWDATA[7:0] & `PPC_B_WPU_MASK;
        `PPC_OFS_OPTION:  pu_dis_n_r <= HWDATA[`PPC_PU_DIS_BIT];
        `PPC_OFS_B_DIR:   b_dir_r   <= HWDATA[7:0];
        `PPC_OFS_C_DIR:   c_dir_r   <= HWDATA[C_W-1:0];
        `PPC_OFS_C_ANSEL: c_ansel_r <= HWDATA[C_W-1:0];
        default: ;
      endcase
    end
  end

  // Output latches; data writes go through rmw, which keeps only the written byte
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      b_lat_r <= `PPC_LAT_RST;
      c_lat_r <= C_W'(`PPC_LAT_RST);
    end else if (ph_r == PPC_WR) begin
      unique case (adr_r)
        `PPC_OFS_B_DATA: b_lat_r <= rmw(b_rd, HWDATA);
        `PPC_OFS_B_LAT:  b_lat_r <= HWDATA[7:0];
        `PPC_OFS_C_DATA: c_lat_r <= C_W'(rmw(8'(c_rd), HWDATA));
        `PPC_OFS_C_LAT:  c_lat_r <= HWDATA[C_W-1:0];
        default: ;
      endcase
    end
  end

  // Read mux; unmapped words read zero
  always_comb begin
    rdata_nxt = '0;
    unique case (HADDR[`PPC_ADDR_W-1:0])
      `PPC_OFS_B_ANSEL: rdata_nxt[7:0] = b_ansel_r;
      `PPC_OFS_B_WPU:   rdata_nxt[7:0] = b_wpu_r;
      `PPC_OFS_OPTION:  rdata_nxt[0]   = pu_dis_n_r;
      `PPC_OFS_B_DATA:  rdata_nxt[7:0] = b_rd;
      `PPC_OFS_B_DIR:   rdata_nxt[7:0] = b_dir_r;
      `PPC_OFS_B_LAT:   rdata_nxt[7:0] = b_lat_r;
      `PPC_OFS_C_DATA:  rdata_nxt[C_W-1:0] = c_rd;
      `PPC_OFS_C_DIR:   rdata_nxt[C_W-1:0] = c_dir_r;
      `PPC_OFS_C_LAT:   rdata_nxt[C_W-1:0] = c_lat_r;
      `PPC_OFS_C_ANSEL: rdata_nxt[C_W-1:0] = c_ansel_r;
      default: ;
    endcase
  end

  // Read data registered at the address phase
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      HRDATA    <= '0;
      HREADYOUT <= 1'b1;
      HRESP     <= 1'b0;
    end else begin
      HREADYOUT <= 1'b1;
      HRESP     <= 1'b0;
      if (take && !HWRITE) begin
        HRDATA <= rdata_nxt;
      end
    end
  end

  // Pad drive: latch always the source, no alternate mux
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      B_PIN_DRIVE <= '0;
      B_PIN_OE    <= '0;
      C_PIN_DRIVE <= '0;
      C_PIN_OE    <= '0;
      B_PULLUP    <= '0;
      B_ANALOG    <= '0;
      C_ANALOG    <= '0;
    end else begin
      B_PIN_DRIVE <= b_lat_r;
      B_PIN_OE    <= ~b_dir_r;
      C_PIN_DRIVE <= c_lat_r;
      C_PIN_OE    <= ~c_dir_r;
      // Pull-up only for inputs with global enable low
      B_PULLUP <= b_wpu_r & b_dir_r & {8{~pu_dis_n_r}};
      B_ANALOG <= b_ansel_r;
      C_ANALOG <= c_ansel_r;
    end
  end

  property p_pullup;
    @(posedge CLK) disable iff (!RST_N)
      ##1 B_PULLUP == $past(b_wpu_r & b_dir_r & {8{~pu_dis_n_r}});
  endproperty
  a_pullup: assert property (p_pullup)
    else $error("pull-up gating wrong");

  property p_oe;
    @(posedge CLK) disable iff (!RST_N)
      ##1 (C_PIN_OE == ~$past(c_dir_r)) && (C_PIN_DRIVE == $past(c_lat_r));
  endproperty
  a_oe: assert property (p_oe)
    else $error("third port drive wrong");

  property p_b_oe;
    @(posedge CLK) disable iff (!RST_N)
      ##1 (B_PIN_OE == ~$past(b_dir_r));
  endproperty
  a_b_oe: assert property (p_b_oe)
    else $error("second port enable wrong");

  property p_ansel_mask;
    @(posedge CLK) disable iff (!RST_N)
      (b_ansel_r & ~`PPC_B_ANSEL_MASK) == 8'h00;
  endproperty
  a_ansel_mask: assert property (p_ansel_mask)
    else $error("unimplemented analog bits set");

  property p_wpu_mask;
    @(posedge CLK) disable iff (!RST_N)
      (b_wpu_r & ~`PPC_B_WPU_MASK) == 8'h00;
  endproperty
  a_wpu_mask: assert property (p_wpu_mask)
    else $error("unimplemented pull-up bits set");

  property p_analog_read;
    @(posedge CLK) disable iff (!RST_N)
      (b_rd & b_ansel_r) == 8'h00;
  endproperty
  a_analog_read: assert property (p_analog_read)
    else $error("analog pin reads one");

  sequence s_data_write;
    ph_r == PPC_WR && adr_r == `PPC_OFS_B_DATA;
  endsequence
  property p_rmw;
    @(posedge CLK) disable iff (!RST_N)
      s_data_write |=> b_lat_r == $past(HWDATA[7:0]);
  endproperty
  a_rmw: assert property (p_rmw)
    else $error("latch not updated by data write");

  property p_ready;
    @(posedge CLK) disable iff (!RST_N)
      HREADYOUT && !HRESP;
  endproperty
  a_ready: assert property (p_ready)
    else $error("slave not ready or error");

  // Rule-level pull-up checks, independent of the gating expression
  property p_pu_out_off;
    @(posedge CLK) disable iff (!RST_N)
      (B_PULLUP & B_PIN_OE) == 8'h00;
  endproperty
  a_pu_out_off: assert property (p_pu_out_off)
    else $error("pull-up on while pin drives");

  property p_pu_global;
    @(posedge CLK) disable iff (!RST_N)
      pu_dis_n_r |=> B_PULLUP == 8'h00;
  endproperty
  a_pu_global: assert property (p_pu_global)
    else $error("pull-up on while globally disabled");

  // Read address phases whose data phase is checked on the bus
  sequence s_rd_b_data;
    take && !HWRITE && HADDR[`PPC_ADDR_W-1:0] == `PPC_OFS_B_DATA;
  endsequence
  sequence s_rd_c_data;
    take && !HWRITE && HADDR[`PPC_ADDR_W-1:0] == `PPC_OFS_C_DATA;
  endsequence
  sequence s_rd_b_ansel;
    take && !HWRITE && HADDR[`PPC_ADDR_W-1:0] == `PPC_OFS_B_ANSEL;
  endsequence

  // What software sees, not the internal mask, is what matters
  property p_rd_analog;
    @(posedge CLK) disable iff (!RST_N)
      s_rd_b_data |=> (HRDATA[7:0] & $past(b_ansel_r)) == 8'h00;
  endproperty
  a_rd_analog: assert property (p_rd_analog)
    else $error("second port analog pin read as one");

  property p_rd_c_analog;
    @(posedge CLK) disable iff (!RST_N)
      s_rd_c_data |=> (HRDATA[C_W-1:0] & $past(c_ansel_r)) == '0;
  endproperty
  a_rd_c_analog: assert property (p_rd_c_analog)
    else $error("third port analog pin read as one");

  property p_rd_ansel;
    @(posedge CLK) disable iff (!RST_N)
      s_rd_b_ansel |=>
        (HRDATA & ~{24'h000000, `PPC_B_ANSEL_MASK}) == 32'h00000000;
  endproperty
  a_rd_ansel: assert property (p_rd_ansel)
    else $error("unimplemented analog bits read back");

  // Latch keeps driving even in analog mode
  property p_b_drive;
    @(posedge CLK) disable iff (!RST_N)
      ##1 B_PIN_DRIVE == $past(b_lat_r);
  endproperty
  a_b_drive: assert property (p_b_drive)
    else $error("second port not driven from latch");
endmodule // ppc_top

// *** sim/ppc_pins.sv ***
`timescale 1ns/1ps
// Board side of one port: pads, outside sources and pull-ups
module ppc_pins #(
  parameter int W = 8
) (
  input  wire logic         clk,
  input  wire logic [W-1:0] pad_drv,
  input  wire logic [W-1:0] pin_oe,
  input  wire logic [W-1:0] pin_pu,
  input  wire logic [W-1:0] ext_v,
  input  wire logic [W-1:0] ext_en,
  output logic      [W-1:0] pad_lvl
);
  logic [W-1:0] flt_r = '0;
  // Floating pads toggle so a stale level is never read back
  always @(posedge clk) begin
    flt_r <= ~flt_r;
  end
  // Own driver first, then outside source, then weak pull-up
  always_comb begin
    for (int i = 0; i < W; i++) begin
      if (pin_oe[i]) pad_lvl[i] = pad_drv[i];
      else if (ext_en[i]) pad_lvl[i] = ext_v[i];
      else if (pin_pu[i]) pad_lvl[i] = 1'b1;
      else pad_lvl[i] = flt_r[i];
    end
  end
endmodule // ppc_pins

// *** sim/testbench.sv ***
`timescale 1ns/1ps
`include "ppc_cfg.svh"
module testbench;
  logic        clk = 0, rst_n = 0, hsel = 0, hwrite = 0, hready, hresp;
  logic [31:0] haddr = '0, hwdata = '0, hrdata, rd;
  logic [1:0]  htrans = 2'b00;
  logic [2:0]  hsize = 3'b010;
  logic [7:0]  b_i, b_o, b_oe, b_pu, b_an, c_i, c_o, c_oe, c_an;
  logic [7:0]  bx = '0, bx_en = '0, cx = '0, cx_en = '0;
  int          errors = 0, tests_run = 0, cyc = 0;

  initial forever #5 clk = ~clk;
  // Watchdog; the whole run needs well under this
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      errors++;
      close_out();
    end
  end

  ppc_top #(.C_W(8)) i_ppc_top (
    .CLK(clk), .RST_N(rst_n), .HSEL(hsel), .HADDR(haddr),
    .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(hsize), .HWDATA(hwdata),
    .HREADY(hready), .HRDATA(hrdata), .HREADYOUT(hready), .HRESP(hresp),
    .B_PIN_LEVEL(b_i), .B_PIN_DRIVE(b_o), .B_PIN_OE(b_oe),
    .B_PULLUP(b_pu), .B_ANALOG(b_an), .C_PIN_LEVEL(c_i),
    .C_PIN_DRIVE(c_o), .C_PIN_OE(c_oe), .C_ANALOG(c_an));
  ppc_pins #(.W(8)) pins_b (.clk(clk), .pad_drv(b_o), .pin_oe(b_oe),
    .pin_pu(b_pu), .ext_v(bx), .ext_en(bx_en), .pad_lvl(b_i));
  ppc_pins #(.W(8)) pins_c (.clk(clk), .pad_drv(c_o), .pin_oe(c_oe),
    .pin_pu(8'h00), .ext_v(cx), .ext_en(cx_en), .pad_lvl(c_i));

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    tests_run++;
    if (g !== e) begin
      errors++;
      $display("BAD t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  // One single word transfer; address held until ready seen high
  task automatic bus(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    @(posedge clk);
    hsel <= 1'b1;
    haddr <= {20'h0, a};
    htrans <= 2'b10;
    hwrite <= w;
    do @(posedge clk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge clk); while (hready !== 1'b1);
    rd = hrdata;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask
  task automatic rdc(input logic [11:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(rd, e);
  endtask
  // Outputs lag a write by one clock, pin reads by three
  task automatic settle();
    repeat (4) @(posedge clk);
    #1;
  endtask

  task automatic t_reset();
    rdc(`PPC_OFS_B_ANSEL, 32'h30);
    rdc(`PPC_OFS_B_WPU, 32'hF0);
    rdc(`PPC_OFS_OPTION, 32'h01);
    rdc(`PPC_OFS_B_DIR, 32'hFF);
    rdc(`PPC_OFS_C_DIR, 32'hFF);
    rdc(`PPC_OFS_B_LAT, 32'h00);
    rdc(`PPC_OFS_C_LAT, 32'h00);
    rdc(`PPC_OFS_C_ANSEL, 32'hFF);
    rdc(12'h100, 32'h0);
    chk({24'h0, b_oe | c_oe}, 32'h0);
    chk({24'h0, b_pu}, 32'h0);
    chk({24'h0, c_an}, 32'hFF);
    chk({31'h0, hresp}, 32'h0);
    chk({31'h0, hready}, 32'h1);
    $display("TEST reset values done");
  endtask
  task automatic t_bits();
    wr(`PPC_OFS_B_ANSEL, 32'hFF);
    rdc(`PPC_OFS_B_ANSEL, 32'h30);
    wr(`PPC_OFS_B_ANSEL, 32'h00);
    rdc(`PPC_OFS_B_ANSEL, 32'h00);
    wr(`PPC_OFS_B_WPU, 32'h0F);
    rdc(`PPC_OFS_B_WPU, 32'h00);
    wr(`PPC_OFS_B_WPU, 32'hFF);
    rdc(`PPC_OFS_B_WPU, 32'hF0);
    wr(12'h100, 32'hFF);
    rdc(12'h100, 32'h0);
    $display("TEST register bits done");
  endtask
  task automatic t_pullup();
    wr(`PPC_OFS_OPTION, 32'h00);
    settle();
    chk({24'h0, b_pu}, 32'hF0);
    wr(`PPC_OFS_B_DIR, 32'h30);
    settle();
    chk({24'h0, b_pu}, 32'h30);
    chk({24'h0, b_oe}, 32'hCF);
    rdc(`PPC_OFS_B_DATA, 32'h30);
    wr(`PPC_OFS_OPTION, 32'h01);
    settle();
    chk({24'h0, b_pu}, 32'h00);
    $display("TEST pull-ups done");
  endtask
  task automatic t_drive();
    wr(`PPC_OFS_C_LAT, 32'hA5);
    wr(`PPC_OFS_C_DIR, 32'h0F);
    @(posedge clk);
    cx <= 8'h0C;
    cx_en <= 8'h0F;
    settle();
    chk({24'h0, c_oe}, 32'hF0);
    chk({24'h0, c_o}, 32'hA5);
    rdc(`PPC_OFS_C_DATA, 32'h00);
    wr(`PPC_OFS_C_ANSEL, 32'h00);
    settle();
    chk({24'h0, c_an}, 32'h00);
    rdc(`PPC_OFS_C_DATA, 32'hAC);
    wr(`PPC_OFS_C_DATA, 32'h3C);
    rdc(`PPC_OFS_C_LAT, 32'h3C);
    settle();
    chk({24'h0, c_o}, 32'h3C);
    $display("TEST third port drive done");
  endtask
  task automatic t_analog();
    // Analog pins 5:4 start as inputs, then software makes every pin an output
    wr(`PPC_OFS_B_ANSEL, 32'h30);
    @(posedge clk);
    bx <= 8'hFF;
    bx_en <= 8'h30;
    settle();
    chk({24'h0, b_an}, 32'h30);
    rdc(`PPC_OFS_B_DATA, 32'h00);
    wr(`PPC_OFS_B_LAT, 32'hFF);
    wr(`PPC_OFS_B_DIR, 32'h00);
    settle();
    chk({24'h0, b_oe & b_o}, 32'hFF);
    rdc(`PPC_OFS_B_DATA, 32'hCF);
    // Data write lands in the latch; analog pins still read zero
    wr(`PPC_OFS_B_DATA, 32'h5A);
    rdc(`PPC_OFS_B_LAT, 32'h5A);
    settle();
    chk({24'h0, b_o}, 32'h5A);
    rdc(`PPC_OFS_B_DATA, 32'h4A);
    $display("TEST analog select done");
  endtask

  task automatic close_out();
    $display("COUNTS errors=%0d tests_run=%0d", errors, tests_run);
    if (errors == 0 && tests_run > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  initial begin
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    t_reset();
    t_bits();
    t_pullup();
    t_drive();
    t_analog();
    close_out();
  end
endmodule // testbench
